// >>> bench/itm_assertions.sv
// concurrent checks on the ports of the two-wire master
`timescale 1ns/1ps
`include "itm_defs.vh"
module itm_assertions (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // register bus
  input wire logic [1:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic AVS_WAITREQUEST_O,
  // bus lines and wake request
  input wire logic SCL_I,
  input wire logic SCL_O,
  input wire logic SCL_OE_O,
  input wire logic SDA_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_O,
  input wire logic IRQ_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // ======
  // helper: shadow of the reload and length of each scl low phase
  reg [6:0] baud;
  reg [7:0] low_cnt;
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      baud <= `ITM_BAUD_RST;
      low_cnt <= 8'h00;
    end else begin
      if (AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == 2'h3)
        baud <= AVS_WRITEDATA_I[6:0];
      low_cnt <= !SCL_OE_O ? 8'h00 : (&low_cnt ? low_cnt : low_cnt + 8'h01);
    end
  end
  // ======
  // sequences and assertions
  sequence s_req;
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O;
  endsequence
  sequence s_ans;
    !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O;
  endsequence
  ans_timing_a: assert property (s_req |=> s_ans)
    else $error("bus answer not a one-cycle low waitrequest");
  idle_wait_a: assert property (!AVS_READ_I && !AVS_WRITE_I
    |=> AVS_WAITREQUEST_O)
    else $error("waitrequest low without a request");
  rd_hold_a: assert property (!AVS_READ_I |=> $stable(AVS_READDATA_O))
    else $error("read data moved without a read");
  scl_lowonly_a: assert property (SCL_O == 1'b0)
    else $error("scl driven high");
  sda_lowonly_a: assert property (SDA_O == 1'b0)
    else $error("sda driven high");
  rst_quiet_a: assert property (disable iff (1'b0)
    RST_I && $past(RST_I) |-> AVS_WAITREQUEST_O && !SCL_OE_O && !SDA_OE_O
    && !IRQ_O)
    else $error("outputs active during reset");
  sda_pull_a: assert property ($rose(SDA_OE_O) |-> SCL_OE_O)
    else $error("sda pulled low while scl not held low");
  scl_lowtime_a: assert property ($fell(SCL_OE_O) |->
    low_cnt > {1'b0, baud})
    else $error("scl low phase shorter than one baud period");
endmodule // itm_assertions

bind itm_master itm_assertions itm_assertions_inst (
  .CLK_I(CLK_I), .RST_I(RST_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
  .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
  .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_READDATA_O(AVS_READDATA_O),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .SCL_I(SCL_I), .SCL_O(SCL_O),
  .SCL_OE_O(SCL_OE_O), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O),
  .IRQ_O(IRQ_O));

// >>> bench/itm_master_tb_top.sv
// self-checking bench for the two-wire master
`timescale 1ns/1ps
module itm_master_tb_top;
  // ======
  // stimulus and wires
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] adr = 2'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic sync = 1'b0;
  logic stx = 1'b0;
  logic nack = 1'b0;
  logic grab = 1'b0;
  logic [7:0] tbyte = 8'h00;
  logic [3:0] stretch = 4'h0;
  logic [31:0] r = 32'h31910dd9;
  logic [31:0] q;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  wire [31:0] rdata;
  wire wreq, scl_oe, sda_oe, irq, s_scl_oe, s_sda_oe;
  wire [7:0] s_rx;
  // open-drain lines with pull-ups; grab is a rival master on sda
  wire scl = !(scl_oe || s_scl_oe);
  wire sda = !(sda_oe || s_sda_oe || grab);
  itm_master itm_master_inst (.CLK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(adr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq), .SCL_I(scl), .SCL_O(),
    .SCL_OE_O(scl_oe), .SDA_I(sda), .SDA_O(), .SDA_OE_O(sda_oe), .IRQ_O(irq));
  itm_slave_model itm_slave_model_inst (.clk_i(clk), .scl_i(scl), .sda_i(sda),
    .sync_i(sync), .slave_tx_i(stx), .nack_i(nack), .tx_byte_i(tbyte),
    .stretch_i(stretch), .sda_oe_o(s_sda_oe), .scl_oe_o(s_scl_oe),
    .rx_byte_o(s_rx));
  initial forever #4 clk = ~clk;
  // ======
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic tally_and_finish;
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  task automatic av(input logic [1:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic poll(input logic [1:0] a, input int b, input logic v);
    int n;
    n = 0;
    do begin av(a, 1'b0, 32'h0); n++; end while (q[b] !== v && n < 300);
    chkb(q[b], v);
  endtask
  task automatic frame(input logic tx_side, input logic [7:0] b);
    stx <= tx_side;
    tbyte <= b;
    sync <= 1'b1;
    @(posedge clk);
    sync <= 1'b0;
  endtask
  task automatic tx(input logic [7:0] b, input logic nk);
    nack <= nk;
    frame(1'b0, 8'h00);
    av(2'h0, 1'b1, {24'h0, b});
    av(2'h1, 1'b0, 32'h0);
    chkb(q[0], 1'b1);
    av(2'h0, 1'b1, 32'h5a);
    av(2'h2, 1'b1, 32'h8);
    poll(2'h1, 5, 1'b1);
    chk({24'h0, s_rx}, {24'h0, b});
    av(2'h1, 1'b0, 32'h0);
    chkb(q[0], 1'b0);
    chkb(q[6], 1'b1);
    av(2'h2, 1'b0, 32'h0);
    chkb(q[6], nk);
    chkb(q[3], 1'b0);
    av(2'h1, 1'b1, 32'h200);
  endtask
  task automatic rxb(input logic [7:0] b, input logic rb, input logic ov);
    frame(1'b1, b);
    av(2'h2, 1'b1, 32'h8);
    poll(2'h1, 5, 1'b1);
    poll(2'h2, 3, 1'b0);
    av(2'h1, 1'b0, 32'h0);
    chkb(q[0], 1'b1);
    chkb(q[7], ov);
    if (rb) begin
      av(2'h0, 1'b0, 32'h0);
      chk({24'h0, q[7:0]}, {24'h0, b});
      av(2'h1, 1'b0, 32'h0);
      chkb(q[0], 1'b0);
    end
    stx <= 1'b0;
    av(2'h1, 1'b1, 32'h200);
  endtask
  task automatic ack(input logic nk);
    av(2'h2, 1'b1, {26'h0, nk, 5'h10});
    poll(2'h2, 4, 1'b0);
  endtask
  // ======
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      tally_and_finish;
    end
  end
  // ======
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    av(2'h3, 1'b0, 32'h0);
    chk(q, 32'h13);
    av(2'h3, 1'b1, 32'h87);
    av(2'h3, 1'b0, 32'h0);
    chk(q, 32'h7);
    av(2'h0, 1'b1, 32'h3c);
    av(2'h1, 1'b0, 32'h0);
    chkb(q[6], 1'b1);
    av(2'h1, 1'b1, 32'h200);
    for (int i = 0; i < 6; i++) begin
      r = xs(r);
      stretch <= r[12:9];
      tx(i == 0 ? 8'h00 : (i == 1 ? 8'hff : r[7:0]), r[8]);
    end
    stretch <= 4'h0;
    r = xs(r);
    rxb(r[7:0], 1'b1, 1'b0);
    ack(1'b0);
    rxb(r[15:8], 1'b0, 1'b0);
    ack(1'b1);
    rxb(r[23:16], 1'b0, 1'b1);
    av(2'h2, 1'b1, 32'h4);
    poll(2'h2, 2, 1'b0);
    av(2'h1, 1'b0, 32'h0);
    chkb(q[4], 1'b1);
    chkb(q[5], 1'b1);
    chkb(scl && sda, 1'b1);
    av(2'h1, 1'b1, 32'h200);
    grab <= 1'b1;
    frame(1'b0, 8'h00);
    av(2'h0, 1'b1, 32'hff);
    poll(2'h1, 8, 1'b1);
    chkb(q[0], 1'b0);
    chkb(irq, 1'b1);
    av(2'h1, 1'b1, 32'h200);
    av(2'h2, 1'b1, 32'h30);
    poll(2'h1, 8, 1'b1);
    av(2'h2, 1'b0, 32'h0);
    chkb(q[4], 1'b0);
    grab <= 1'b0;
    poll(2'h1, 4, 1'b1);
    chkb(q[5], 1'b1);
    av(2'h1, 1'b1, 32'h200);
    tx(8'hc3, 1'b0);
    av(2'h1, 1'b1, 32'h0);
    av(2'h1, 1'b0, 32'h0);
    chkb(q[4], 1'b0);
    av(2'h1, 1'b1, 32'h200);
    frame(1'b0, 8'h00);
    av(2'h0, 1'b1, 32'ha5);
    repeat (30) @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    av(2'h1, 1'b0, 32'h0);
    chk(q, 32'h0);
    chkb(scl, 1'b1);
    tally_and_finish;
  end
endmodule // itm_master_tb_top

// >>> bench/itm_slave_model.sv
// behavioural slave on the two-wire bus, byte framed by the bench
`timescale 1ns/1ps
module itm_slave_model (
  // clock and bus lines
  input wire logic clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  // bench control
  input wire logic sync_i,
  input wire logic slave_tx_i,
  input wire logic nack_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic [3:0] stretch_i,
  // pull-down enables and captured byte
  output logic sda_oe_o,
  output logic scl_oe_o,
  output logic [7:0] rx_byte_o
);
  logic scl_q = 1'b1;
  logic [3:0] rises = 4'h0;
  logic [3:0] hold = 4'h0;
  initial begin
    sda_oe_o = 1'b0;
    scl_oe_o = 1'b0;
    rx_byte_o = 8'h00;
  end
  // stretch after every fall holds scl low for stretch_i clocks, past the master's own low time only when stretch_i is the longer
  always @(posedge clk_i) begin
    scl_q <= scl_i;
    scl_oe_o <= hold != 4'h0;
    if (hold != 4'h0)
      hold <= hold - 4'h1;
    if (sync_i) begin
      rises <= 4'h0;
      sda_oe_o <= slave_tx_i && !tx_byte_i[7];
    end else if (!scl_q && scl_i) begin
      rises <= rises + 4'h1;
      if (rises < 4'h8)
        rx_byte_o <= {rx_byte_o[6:0], sda_i};
    end else if (scl_q && !scl_i) begin
      hold <= stretch_i;
      if (rises < 4'h8)
        sda_oe_o <= slave_tx_i && !tx_byte_i[3'h7 - rises[2:0]];
      else
        sda_oe_o <= rises == 4'h8 && !slave_tx_i && !nack_i;
    end
  end
endmodule // itm_slave_model

// >>> core/itm_baud_counter.v
// reloadable baud counter producing a one-cycle rollover pulse
`timescale 1ns/1ps
module itm_baud_counter #(
  parameter W = 7
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // control
  input wire run_i,
  input wire load_i,
  input wire [W-1:0] reload_i,
  // status
  output reg roll_o
);
  reg [W-1:0] cnt;
  // two decrements per instruction cycle: one per clock here
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= {W{1'b0}};
      roll_o <= 1'b0;
    end else begin
      roll_o <= 1'b0;
      if (load_i) begin
        cnt <= reload_i;
      end else if (run_i) begin
        if (cnt == {W{1'b0}}) begin
          cnt <= reload_i;
          roll_o <= 1'b1;
        end else begin
          cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // itm_baud_counter

// >>> core/itm_master.v
// two-wire master transfer engine with an Avalon-MM register slave
`timescale 1ns/1ps
`include "itm_defs.vh"
module itm_master (
  // clock and reset
  input wire CLK_I,
  input wire RST_I,
  // avalon-mm slave
  input wire [1:0] AVS_ADDRESS_I,
  input wire AVS_READ_I,
  input wire AVS_WRITE_I,
  input wire [31:0] AVS_WRITEDATA_I,
  output reg [31:0] AVS_READDATA_O,
  output reg AVS_WAITREQUEST_O,
  // bus lines
  input wire SCL_I,
  output reg SCL_O,
  output reg SCL_OE_O,
  input wire SDA_I,
  output reg SDA_O,
  output reg SDA_OE_O,
  // processor wake request
  output reg IRQ_O
);
  // ==========================================================
  // states
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_TX = 3'h1;
  localparam [2:0] S_RX = 3'h2;
  localparam [2:0] S_ACK = 3'h3;
  localparam [2:0] S_STOP = 3'h4;

  // ==========================================================
  // input synchronisers
  reg scl_m, scl_s, sda_m, sda_s, scl_d, sda_d;
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= SCL_I;
      scl_s <= scl_m;
      sda_m <= SDA_I;
      sda_s <= sda_m;
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end
  wire start_seen = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_seen = scl_s & scl_d & ~sda_d & sda_s;

  // ==========================================================
  // registers
  reg [7:0] transfer_buffer;
  reg [7:0] bit_shift_reg;
  reg [6:0] address_baud_reg;
  reg port_enable;
  reg buffer_full_flag, ack_data_bit, ack_status_bit, serial_irq_flag;
  reg rx_enable_bit, ack_sequence_enable, stop_sequence_enable;
  reg rx_overflow_flag, write_collision_flag, bus_collision_flag;
  reg start_flag, stop_flag;
  reg [2:0] state;
  reg [3:0] bit_cnt;
  reg [1:0] phase;
  reg scl_low, sda_low;
  reg run, load;
  reg await_stop;
  wire roll;

  itm_baud_counter #(.W(`ITM_BAUD_W)) u_baud (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .run_i(run),
    .load_i(load),
    .reload_i(address_baud_reg),
    .roll_o(roll)
  );

  wire acc = (AVS_READ_I | AVS_WRITE_I) & AVS_WAITREQUEST_O;
  // writes and buffer-read side effects land on the completing edge
  wire wr = AVS_WRITE_I & ~AVS_WAITREQUEST_O;
  wire rd = AVS_READ_I & AVS_WAITREQUEST_O;
  wire rd_done = AVS_READ_I & ~AVS_WAITREQUEST_O;
  wire wr_buf = wr & (AVS_ADDRESS_I == `ITM_REG_BUF);
  wire wr_ctl = wr & (AVS_ADDRESS_I == `ITM_REG_CTL2);
  wire wr_st = wr & (AVS_ADDRESS_I == `ITM_REG_STAT);
  wire rd_buf = rd_done & (AVS_ADDRESS_I == `ITM_REG_BUF);
  wire idle = (state == S_IDLE);
  // sda released but sampled low while scl high: lost arbitration
  wire lost = scl_s & ~sda_low & ~sda_s;

  // ==========================================================
  // engine; flags set by hardware win over software clears
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state <= S_IDLE;
      transfer_buffer <= 8'h00;
      bit_shift_reg <= 8'h00;
      address_baud_reg <= `ITM_BAUD_RST;
      port_enable <= 1'b0;
      buffer_full_flag <= 1'b0;
      ack_data_bit <= 1'b0;
      ack_status_bit <= 1'b0;
      serial_irq_flag <= 1'b0;
      rx_enable_bit <= 1'b0;
      ack_sequence_enable <= 1'b0;
      stop_sequence_enable <= 1'b0;
      rx_overflow_flag <= 1'b0;
      write_collision_flag <= 1'b0;
      bus_collision_flag <= 1'b0;
      start_flag <= 1'b0;
      stop_flag <= 1'b0;
      bit_cnt <= 4'h0;
      phase <= 2'h0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      run <= 1'b0;
      load <= 1'b0;
      await_stop <= 1'b0;
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O <= 32'h00000000;
    end else begin
      load <= 1'b0;
      AVS_WAITREQUEST_O <= ~acc;
      // ---- software side of the flags
      if (wr_st) begin
        if (!AVS_WRITEDATA_I[`ITM_ST_IRQ]) serial_irq_flag <= 1'b0;
        if (!AVS_WRITEDATA_I[`ITM_ST_WRITE_COLLISION_FLAG]) write_collision_flag <= 1'b0;
        if (!AVS_WRITEDATA_I[`ITM_ST_OV]) rx_overflow_flag <= 1'b0;
        if (!AVS_WRITEDATA_I[`ITM_ST_BCOL]) bus_collision_flag <= 1'b0;
        port_enable <= AVS_WRITEDATA_I[`ITM_ST_ENABLE];
      end
      if (wr & (AVS_ADDRESS_I == `ITM_REG_BAUD))
        address_baud_reg <= AVS_WRITEDATA_I[6:0];
      if (rd_buf) buffer_full_flag <= 1'b0;
      if (start_seen) begin
        start_flag <= 1'b1;
        stop_flag <= 1'b0;
      end
      if (stop_seen) begin
        stop_flag <= 1'b1;
        start_flag <= 1'b0;
        if (await_stop) begin
          serial_irq_flag <= 1'b1;
          await_stop <= 1'b0;
        end
      end
      if (wr_buf) begin
        if (!idle || !port_enable) begin
          write_collision_flag <= 1'b1;
        end else begin
          transfer_buffer <= AVS_WRITEDATA_I[7:0];
          bit_shift_reg <= AVS_WRITEDATA_I[7:0];
          buffer_full_flag <= 1'b1;
          state <= S_TX;
          bit_cnt <= 4'h0;
          phase <= 2'h0;
          load <= 1'b1;
          run <= 1'b1;
        end
      end
      if (wr_ctl) begin
        ack_data_bit <= AVS_WRITEDATA_I[`ITM_C2_ACK_DATA_BIT];
        if (idle && port_enable && !wr_buf) begin
          if (AVS_WRITEDATA_I[`ITM_C2_RX_ENABLE_BIT]) begin
            rx_enable_bit <= 1'b1;
            state <= S_RX;
            bit_cnt <= 4'h0;
            phase <= 2'h0;
            load <= 1'b1;
            run <= 1'b1;
          end else if (AVS_WRITEDATA_I[`ITM_C2_ACK_SEQUENCE_ENABLE]) begin
            ack_sequence_enable <= 1'b1;
            state <= S_ACK;
            scl_low <= 1'b1;
            sda_low <= ~AVS_WRITEDATA_I[`ITM_C2_ACK_DATA_BIT];
            phase <= 2'h0;
            load <= 1'b1;
            run <= 1'b1;
          end else if (AVS_WRITEDATA_I[`ITM_C2_PEN]) begin
            stop_sequence_enable <= 1'b1;
            state <= S_STOP;
            sda_low <= 1'b1;
            phase <= 2'h0;
            run <= 1'b0;
          end
        end
      end
      // ---- transfer sequencer
      case (state)
        S_TX: begin
          if (phase == 2'h0) begin
            // scl low: put out next bit, then wait one period
            scl_low <= 1'b1;
            if (bit_cnt < 4'h8)
              sda_low <= ~bit_shift_reg[7];
            else
              sda_low <= 1'b0;
            if (roll) begin
              scl_low <= 1'b0;
              run <= 1'b0;
              phase <= 2'h1;
            end
          end else if (phase == 2'h1) begin
            if (scl_s) begin
              run <= 1'b1;
              load <= 1'b1;
              phase <= 2'h2;
            end
          end else begin
            if (bit_cnt < 4'h8 && lost) begin
              bus_collision_flag <= 1'b1;
              buffer_full_flag <= 1'b0;
              scl_low <= 1'b0;
              sda_low <= 1'b0;
              run <= 1'b0;
              await_stop <= 1'b1;
              state <= S_IDLE;
            end else if (roll) begin
              scl_low <= 1'b1;
              bit_shift_reg <= {bit_shift_reg[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
              phase <= 2'h0;
              if (bit_cnt == 4'h7) begin
                buffer_full_flag <= 1'b0;
                sda_low <= 1'b0;
              end
              if (bit_cnt == 4'h8) begin
                ack_status_bit <= sda_s;
                serial_irq_flag <= 1'b1;
                run <= 1'b0;
                state <= S_IDLE;
              end
            end
          end
        end
        S_RX: begin
          sda_low <= 1'b0;
          if (phase == 2'h0) begin
            scl_low <= 1'b1;
            if (roll) begin
              scl_low <= 1'b0;
              run <= 1'b0;
              phase <= 2'h1;
            end
          end else if (phase == 2'h1) begin
            if (scl_s) begin
              run <= 1'b1;
              load <= 1'b1;
              phase <= 2'h2;
            end
          end else if (roll) begin
            scl_low <= 1'b1;
            bit_shift_reg <= {bit_shift_reg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
            phase <= 2'h0;
            if (bit_cnt == 4'h7) begin
              rx_enable_bit <= 1'b0;
              transfer_buffer <= {bit_shift_reg[6:0], sda_s};
              buffer_full_flag <= 1'b1;
              if (buffer_full_flag && !rd_buf)
                rx_overflow_flag <= 1'b1;
              serial_irq_flag <= 1'b1;
              run <= 1'b0;
              state <= S_IDLE;
            end
          end
        end
        S_ACK: begin
          if (phase == 2'h0) begin
            if (roll) begin
              scl_low <= 1'b0;
              run <= 1'b0;
              phase <= 2'h1;
            end
          end else if (phase == 2'h1) begin
            if (scl_s) begin
              run <= 1'b1;
              load <= 1'b1;
              phase <= 2'h2;
            end
          end else if (lost) begin
            bus_collision_flag <= 1'b1;
            ack_sequence_enable <= 1'b0;
            scl_low <= 1'b0;
            sda_low <= 1'b0;
            run <= 1'b0;
            await_stop <= 1'b1;
            state <= S_IDLE;
          end else if (roll) begin
            scl_low <= 1'b1;
            ack_sequence_enable <= 1'b0;
            run <= 1'b0;
            state <= S_IDLE;
          end
        end
        S_STOP: begin
          if (phase == 2'h0) begin
            if (!sda_s) begin
              load <= 1'b1;
              run <= 1'b1;
              phase <= 2'h1;
            end
          end else if (phase == 2'h1) begin
            if (roll) begin
              scl_low <= 1'b0;
              run <= 1'b0;
              phase <= 2'h2;
            end
          end else if (phase == 2'h2) begin
            if (scl_s) begin
              run <= 1'b1;
              load <= 1'b1;
              phase <= 2'h3;
              bit_cnt <= 4'h0;
            end
          end else if (bit_cnt == 4'h0) begin
            if (roll) begin
              sda_low <= 1'b0;
              bit_cnt <= 4'h1;
            end
          end else if (roll) begin
            // one period after sda is released, the stop must have been seen on the lines
            if (stop_flag) begin
              stop_sequence_enable <= 1'b0;
              serial_irq_flag <= 1'b1;
              run <= 1'b0;
              state <= S_IDLE;
            end else begin
              bus_collision_flag <= 1'b1;
              stop_sequence_enable <= 1'b0;
              run <= 1'b0;
              await_stop <= 1'b1;
              state <= S_IDLE;
            end
          end
        end
        default: begin
          if (!wr_buf && !wr_ctl) run <= 1'b0;
        end
      endcase
      // disabling the port ends everything and clears the start and stop flags
      if (!port_enable) begin
        state <= S_IDLE;
        scl_low <= 1'b0;
        sda_low <= 1'b0;
        run <= 1'b0;
        rx_enable_bit <= 1'b0;
        ack_sequence_enable <= 1'b0;
        stop_sequence_enable <= 1'b0;
        start_flag <= 1'b0;
        stop_flag <= 1'b0;
        await_stop <= 1'b0;
      end
      // ---- read data
      if (rd) begin
        case (AVS_ADDRESS_I)
          `ITM_REG_BUF: AVS_READDATA_O <= {24'h000000, transfer_buffer};
          `ITM_REG_STAT: AVS_READDATA_O <= {22'h000000, port_enable,
            bus_collision_flag, rx_overflow_flag, write_collision_flag,
            serial_irq_flag, stop_flag, start_flag, 2'h0,
            buffer_full_flag};
          `ITM_REG_CTL2: AVS_READDATA_O <= {25'h0000000, ack_status_bit,
            ack_data_bit, ack_sequence_enable, rx_enable_bit,
            stop_sequence_enable, 2'h0};
          default: AVS_READDATA_O <= {25'h0000000, address_baud_reg};
        endcase
      end
    end
  end

  // ==========================================================
  // pins: scl and sda open drain only, their output value is always low; IRQ_O driven from the flags
  always @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      SCL_O <= 1'b0;
      SCL_OE_O <= 1'b0;
      SDA_O <= 1'b0;
      SDA_OE_O <= 1'b0;
      IRQ_O <= 1'b0;
    end else begin
      SCL_O <= 1'b0;
      SDA_O <= 1'b0;
      SCL_OE_O <= scl_low;
      SDA_OE_O <= sda_low;
      IRQ_O <= serial_irq_flag | bus_collision_flag;
    end
  end
endmodule // itm_master

// >>> shared/itm_defs.vh
// register map, field positions and reset values of the two-wire master
`ifndef ITM_DEFS_VH
`define ITM_DEFS_VH
// word offsets (byte addresses = offset * 4)
`define ITM_REG_BUF 2'h0
`define ITM_REG_STAT 2'h1
`define ITM_REG_CTL2 2'h2
`define ITM_REG_BAUD 2'h3
// control_reg_two fields
`define ITM_C2_PEN 2
`define ITM_C2_RX_ENABLE_BIT 3
`define ITM_C2_ACK_SEQUENCE_ENABLE 4
`define ITM_C2_ACK_DATA_BIT 5
`define ITM_C2_ACK_STATUS_BIT 6
// port_status_reg fields
`define ITM_ST_BF 0
`define ITM_ST_START 3
`define ITM_ST_STOP 4
`define ITM_ST_IRQ 5
`define ITM_ST_WRITE_COLLISION_FLAG 6
`define ITM_ST_OV 7
`define ITM_ST_BCOL 8
`define ITM_ST_ENABLE 9
// reset value and width of the baud reload
`define ITM_BAUD_RST 7'h13
`define ITM_BAUD_W 7
`endif
